// File: common/sipo_shifter_regs.svh
`ifndef SIPO_SHIFTER_REGS_SVH
`define SIPO_SHIFTER_REGS_SVH

// ****************************************************************
// stage geometry
// ****************************************************************
`define SIPO_STAGE_COUNT   8
`define SIPO_FIRST_STAGE   0
`define SIPO_LAST_STAGE    7
`define SIPO_CLEAR_VALUE   8'h00

// ****************************************************************
// pin synchroniser geometry
// ****************************************************************
`define SIPO_SYNC_DEPTH    2
`define SIPO_PIN_COUNT     4
`define SIPO_PIN_CLK       0
`define SIPO_PIN_CLR       1
`define SIPO_PIN_SA        2
`define SIPO_PIN_SB        3
`define SIPO_PIN_RESET     4'h0

`endif

// File: common/sipo_shifter_pkg.sv
package sipo_shifter_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [7:0] stage_vec_t;
  typedef logic [3:0] pin_vec_t;

endpackage : sipo_shifter_pkg

// File: core/pin_sync.sv
`timescale 1ns/1ps

// ****************************************************************
// two flip-flop synchroniser per bit
// ****************************************************************
module pin_sync #(
  parameter int          WIDTH     = 4,
  parameter logic [3:0]  RESET_VAL = 4'h0
) (
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // first flop, read only by the second
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= RESET_VAL[WIDTH-1:0];
    end else begin
      meta <= async_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_o <= RESET_VAL[WIDTH-1:0];
    end else begin
      sync_o <= meta;
    end
  end

endmodule : pin_sync

// File: core/serial_in_parallel_out_shifter.sv
`timescale 1ns/1ps
`include "sipo_shifter_regs.svh"

// Overview of operation
// - eight storage stages are held and each stage drives its own parallel output bit.
// - on each rising shift clock with clear inactive every stage after the first takes the previous stage's value.
// - on that edge the first stage takes the AND of both serial inputs sampled just before the edge.
// - a low master clear empties all stages at once, overriding clock and data, and drives outputs low.
// - the last stage output feeds the serial input of a following device on the same clock to chain stages.
module serial_in_parallel_out_shifter #(
  parameter int STAGES = `SIPO_STAGE_COUNT
) (
  input  wire logic                        mclk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        shift_clock_i,
  input  wire logic                        master_clear_n_i,
  input  wire logic                        serial_in_a_i,
  input  wire logic                        serial_in_b_i,
  output logic      [STAGES-1:0]           stage_o,
  output logic                             first_stage_out_o,
  output logic                             last_stage_out_o
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  sipo_shifter_pkg::pin_vec_t pins_raw;
  sipo_shifter_pkg::pin_vec_t pins_sync;
  logic                       clk_seen;
  logic                       data_before;
  logic                       shift_pulse;
  logic                       next_first;
  logic                       clear_n;

  assign pins_raw[`SIPO_PIN_CLK] = shift_clock_i;
  assign pins_raw[`SIPO_PIN_CLR] = master_clear_n_i;
  assign pins_raw[`SIPO_PIN_SA]  = serial_in_a_i;
  assign pins_raw[`SIPO_PIN_SB]  = serial_in_b_i;

  pin_sync #(
    .WIDTH     (`SIPO_PIN_COUNT),
    .RESET_VAL (`SIPO_PIN_RESET)
  ) u_pin_sync (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .async_i (pins_raw),
    .sync_o  (pins_sync)
  );

  // ****************************************************************
  // shift clock edge and pre-edge data
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_seen <= 1'b0;
    end else begin
      clk_seen <= pins_sync[`SIPO_PIN_CLK];
    end
  end

  // data as it stood one cycle before the edge was seen
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_before <= 1'b0;
    end else begin
      data_before <= pins_sync[`SIPO_PIN_SA] & pins_sync[`SIPO_PIN_SB];
    end
  end

  // rising edge, and clear released on the synchronised side as well
  assign shift_pulse = pins_sync[`SIPO_PIN_CLK] & ~clk_seen & pins_sync[`SIPO_PIN_CLR];
  assign next_first  = data_before;

  // ****************************************************************
  // stages
  // ****************************************************************
  // master clear acts without the clock
  assign clear_n = rstn_i & master_clear_n_i;

  always_ff @(posedge mclk_i or negedge clear_n) begin
    if (!clear_n) begin
      stage_o[`SIPO_FIRST_STAGE] <= 1'b0;
    end else if (shift_pulse) begin
      stage_o[`SIPO_FIRST_STAGE] <= next_first;
    end
  end

  for (genvar i = 1; i < STAGES; i++) begin : g_stage
    always_ff @(posedge mclk_i or negedge clear_n) begin
      if (!clear_n) begin
        stage_o[i] <= 1'b0;
      end else if (shift_pulse) begin
        stage_o[i] <= stage_o[i-1];
      end
    end
  end

  // separate copies of the end stages, chain tap on the last
  always_ff @(posedge mclk_i or negedge clear_n) begin
    if (!clear_n) begin
      first_stage_out_o <= 1'b0;
    end else if (shift_pulse) begin
      first_stage_out_o <= next_first;
    end
  end

  always_ff @(posedge mclk_i or negedge clear_n) begin
    if (!clear_n) begin
      last_stage_out_o <= 1'b0;
    end else if (shift_pulse) begin
      last_stage_out_o <= stage_o[STAGES-2];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic [3:0] ones_run;

  always_ff @(posedge mclk_i or negedge clear_n) begin
    if (!clear_n) begin
      ones_run <= 4'h0;
    end else if (shift_pulse) begin
      ones_run <= next_first ? ((ones_run == 4'hF) ? ones_run : ones_run + 4'h1) : 4'h0;
    end
  end

  // ****************************************************************
  // properties
  // ****************************************************************

  shift_move_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse |=> stage_o[STAGES-1:1] == $past(stage_o[STAGES-2:0]))
    else $error("stages did not move one place on a shift");

  edge_latency_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse |-> $past(shift_clock_i, 2) && !$past(shift_clock_i, 3))
    else $error("shift not caused by a rising shift clock two cycles back");

  first_load_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse |=> stage_o[0] == $past(serial_in_a_i & serial_in_b_i, 4))
    else $error("first stage did not take the pre-edge serial AND");

  clear_out_a : assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !master_clear_n_i |-> (stage_o == '0) && !first_stage_out_o && !last_stage_out_o)
    else $error("outputs not low while master clear is low");

  hold_stable_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    !shift_pulse |=> $stable(stage_o))
    else $error("stages changed without a shift clock edge");

  end_taps_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    first_stage_out_o == stage_o[0])
    else $error("first stage output differs from stage zero");

  chain_tap_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse |=> last_stage_out_o == $past(stage_o[STAGES-2]))
    else $error("chain tap did not take the stage before the last");

  fill_ones_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    (ones_run >= 4'h8) |-> stage_o == '1)
    else $error("eight shifted ones did not fill the register");

  shift_once_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse |=> !shift_pulse)
    else $error("one rising shift clock edge shifted twice");

  data_gate_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse && !$past(serial_in_a_i, 3) |=> !stage_o[0])
    else $error("low serial input a did not block a one");

  enable_gate_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse && !$past(serial_in_b_i, 3) |=> !stage_o[0])
    else $error("low serial input b did not block a one");

  clear_sync_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse |-> $past(master_clear_n_i, 2))
    else $error("shift while master clear was still seen low");

  clear_release_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    $rose(master_clear_n_i) |-> !shift_pulse ##1 !shift_pulse)
    else $error("shift too soon after master clear release");

  tap_stable_a : assert property (
    @(posedge mclk_i) disable iff (!clear_n)
    !shift_pulse |=> $stable(first_stage_out_o) && $stable(last_stage_out_o))
    else $error("end taps changed without a shift clock edge");

  // ****************************************************************
  // cover points
  // ****************************************************************

  shift_one_c : cover property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse && next_first);

  clear_busy_c : cover property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (stage_o != '0) ##1 !master_clear_n_i);

  full_ones_c : cover property (
    @(posedge mclk_i) disable iff (!clear_n)
    stage_o == '1);

  zero_entry_c : cover property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse && !next_first);

  chain_carry_c : cover property (
    @(posedge mclk_i) disable iff (!clear_n)
    shift_pulse && stage_o[STAGES-1]);

endmodule : serial_in_parallel_out_shifter

// File: test/upstream_driver.sv
`timescale 1ns/1ps

// ****************************************************************
// upstream logic driving the shifter pins
// ****************************************************************
module upstream_driver (
  input  wire logic mclk_i,
  output logic      shift_clock_o,
  output logic      master_clear_n_o,
  output logic      serial_in_a_o,
  output logic      serial_in_b_o
);
  initial begin
    shift_clock_o    = 1'b0;
    master_clear_n_o = 1'b1;
    serial_in_a_o    = 1'b0;
    serial_in_b_o    = 1'b0;
  end

  // mode 0 joined, 1 b held high, 2 a held high
  task automatic send_bit(input logic val, input int mode);
    @(negedge mclk_i);
    serial_in_a_o = (mode == 2) ? 1'b1 : val;
    serial_in_b_o = (mode == 1) ? 1'b1 : val;
    repeat (2) @(negedge mclk_i);
    shift_clock_o = 1'b1;
    repeat (2) @(negedge mclk_i);
    shift_clock_o = 1'b0;
    serial_in_a_o = (mode == 2) ? 1'b1 : ~serial_in_a_o;
    serial_in_b_o = (mode == 1) ? 1'b1 : ~serial_in_b_o;
    repeat (2) @(negedge mclk_i);
  endtask : send_bit

  // clear held while the shift clock pulses
  task automatic pulse_clear();
    repeat (2) @(negedge mclk_i);
    master_clear_n_o = 1'b0;
    serial_in_a_o    = 1'b1;
    serial_in_b_o    = 1'b1;
    repeat (2) @(negedge mclk_i);
    shift_clock_o = 1'b1;
    repeat (3) @(negedge mclk_i);
    shift_clock_o = 1'b0;
    repeat (3) @(negedge mclk_i);
    master_clear_n_o = 1'b1;
    repeat (4) @(negedge mclk_i);
  endtask : pulse_clear
endmodule : upstream_driver

// File: test/testbench.sv
`timescale 1ns/1ps

module testbench;
  logic                         mclk_i;
  logic                         rstn_i;
  logic                         shift_clock_i;
  logic                         master_clear_n_i;
  logic                         serial_in_a_i;
  logic                         serial_in_b_i;
  sipo_shifter_pkg::stage_vec_t stage_o;
  sipo_shifter_pkg::stage_vec_t chain_stage;
  logic                         first_stage_out_o;
  logic                         last_stage_out_o;
  logic [15:0]                  exp_vec;
  logic [15:0]                  shift_note;
  logic [15:0]                  clr_note;
  logic [15:0]                  note_q[$];
  logic                         bit_val;
  int                           error_cnt;
  int                           check_count;
  int                           seed_val;

  // ****************************************************************
  // pins, device and chained second device on one clock
  // ****************************************************************
  upstream_driver drv (.mclk_i(mclk_i), .shift_clock_o(shift_clock_i), .master_clear_n_o(master_clear_n_i),
    .serial_in_a_o(serial_in_a_i), .serial_in_b_o(serial_in_b_i));
  serial_in_parallel_out_shifter dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .shift_clock_i(shift_clock_i),
    .master_clear_n_i(master_clear_n_i), .serial_in_a_i(serial_in_a_i), .serial_in_b_i(serial_in_b_i),
    .stage_o(stage_o), .first_stage_out_o(first_stage_out_o), .last_stage_out_o(last_stage_out_o));
  serial_in_parallel_out_shifter dut_chain (.mclk_i(mclk_i), .rstn_i(rstn_i), .shift_clock_i(shift_clock_i),
    .master_clear_n_i(master_clear_n_i), .serial_in_a_i(last_stage_out_o), .serial_in_b_i(1'b1),
    .stage_o(chain_stage), .first_stage_out_o(), .last_stage_out_o());

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    check_count++;
    if (seen !== expv) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // ****************************************************************
  // stimulus and notes
  // ****************************************************************
  initial begin
    error_cnt   = 0;
    check_count = 0;
    rstn_i      = 1'b0;
    exp_vec     = 16'h0000;
    seed_val    = $urandom(58006);
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i);
    rstn_i = 1'b1;
    check({chain_stage, stage_o}, 16'h0000);
    for (int i = 0; i < 30; i++) begin
      if (i == 20) begin
        exp_vec = 16'h0000;
        note_q.push_back(exp_vec);
        drv.pulse_clear();
      end
      // last eight bits all ones to fill the register
      bit_val = (i >= 22) ? 1'b1 : 1'($urandom % 2);
      exp_vec = {exp_vec[14:0], bit_val};
      note_q.push_back(exp_vec);
      drv.send_bit(bit_val, int'($urandom % 3));
    end
    repeat (4) @(negedge mclk_i);
    check(16'(note_q.size()), 16'h0000);
    finish_test();
  end

  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end

  // ****************************************************************
  // output watchers
  // ****************************************************************
  always @(posedge shift_clock_i) begin
    if (master_clear_n_i === 1'b1) begin
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      shift_note = note_q.pop_front();
      check({chain_stage, stage_o}, shift_note);
      check({14'h0000, last_stage_out_o, first_stage_out_o}, {14'h0000, shift_note[7], shift_note[0]});
      repeat (2) @(negedge mclk_i);
      check({chain_stage, stage_o}, shift_note);
    end
  end

  always @(negedge master_clear_n_i) begin
    #1;
    clr_note = note_q.pop_front();
    check({chain_stage, stage_o}, clr_note);
    repeat (6) @(negedge mclk_i);
    check({chain_stage, stage_o}, clr_note);
  end
endmodule : testbench
